/* File: hw/epiu_top.sv */
`timescale 1ns/100ps
`default_nettype none
// External pin interrupt unit with APB register access
module epiu_top #(
	parameter int STARTUP = epiu_pkg::STARTUP_CYCLES
) (
	input wire logic ref_clk,
	input wire logic rst,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Pins (read back even when driven as outputs) and clock control
	input wire logic [epiu_pkg::NUM_LINES-1:0] ext_irq_pins,
	input wire logic io_clk_en,
	input wire logic wdt_tick,
	// Vectoring side
	input wire logic [epiu_pkg::NUM_LINES-1:0] irq_ack,
	output logic [epiu_pkg::NUM_LINES-1:0] irq_req,
	output logic [epiu_pkg::NUM_LINES-1:0] irq_vector,
	output logic wake_req,
	output logic irq
);
	import epiu_pkg::*;
	typedef struct packed {
		logic [3:0] sync1;
		logic [3:0] sync2;
		logic [3:0] prev;
		logic [7:0] sense;
		logic [3:0] enable;
		logic [3:0] flags;
		logic [1:0] stat;
		logic [1:0] mask;
		logic gie;
		logic pdown;
		logic [31:0] rdata;
	} epiu_state_t;
	epiu_state_t s_ff;
	epiu_state_t nxt_s;
	epiu_wake_if wk ();
	logic wake_pulse;
	logic wake_noirq;
	logic wr_en;
	logic rd_en;
	logic [3:0] edge_hit;
	logic [3:0] level_mode;
	logic [3:0] lvl_req;
	// Sense select of one line
	function automatic epiu_sense_t line_sense(input logic [7:0] sc,
		input int n);
		line_sense = epiu_sense_t'(sc[2*n +: 2]);
	endfunction : line_sense
	// Known APB offsets
	function automatic logic addr_ok(input logic [7:0] a);
		addr_ok = (a == ADDR_SENSE) || (a == ADDR_ENABLE) ||
			(a == ADDR_FLAGS) || (a == ADDR_IRQ_STAT) ||
			(a == ADDR_IRQ_MASK) || (a == ADDR_CTRL);
	endfunction : addr_ok
	// ------------------------------------------------------------
	// Wake sequencer
	// ------------------------------------------------------------
	epiu_wake #(.STARTUP(STARTUP)) u_wake (
		.ref_clk(ref_clk),
		.rst(rst),
		.power_down(s_ff.pdown),
		.wdt_tick(wdt_tick),
		.wk(wk),
		.wake_req(wake_pulse),
		.wake_noirq(wake_noirq)
	);
	// ------------------------------------------------------------
	// Edge and level detection
	// ------------------------------------------------------------
	// Compare successive synchronised samples; the I/O clock gate freezes it
	always_comb begin
		for (int n = 0; n < NUM_LINES; n++) begin
			level_mode[n] = (line_sense(s_ff.sense, n) == SENSE_LOW);
			unique case (line_sense(s_ff.sense, n))
				SENSE_LOW: edge_hit[n] = 1'b0;
				SENSE_ANY: edge_hit[n] = s_ff.sync2[n] ^ s_ff.prev[n]; // [R2]
				SENSE_FALL: edge_hit[n] = s_ff.prev[n] & ~s_ff.sync2[n]; // [R2]
				SENSE_RISE: edge_hit[n] = ~s_ff.prev[n] & s_ff.sync2[n]; // [R2]
			endcase
			edge_hit[n] = edge_hit[n] & io_clk_en; // [R4] [R7] [R8] [R17]
		end
	end
	// Live low level, withheld while a wake waits out its start-up time
	assign lvl_req = level_mode & ~s_ff.sync2 & wk.level_gate; // [R2] [R3]
	assign wk.level_armed = level_mode & s_ff.enable;
	assign wk.pin_low = ~s_ff.sync2;
	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	// Enable gates both sources, whatever drives the pin
	assign irq_req = (s_ff.flags | lvl_req) & s_ff.enable; // [R1] [R3] [R16]
	assign irq_vector = irq_req & {NUM_LINES{s_ff.gie}}; // [R13]
	assign irq = |(s_ff.stat & s_ff.mask);
	assign wake_req = wake_pulse;
	assign wr_en = psel & penable & pwrite;
	assign rd_en = psel & ~penable & ~pwrite;
	// Zero wait states, so the access phase always ends in one cycle
	assign pready = 1'b1;
	assign pslverr = psel & penable & ~addr_ok(paddr);
	assign prdata = s_ff.rdata;
	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb begin
		nxt_s = s_ff;
		// Pins cross from outside: two flops before any logic
		nxt_s.sync1 = ext_irq_pins; // [R17]
		nxt_s.sync2 = s_ff.sync1; // [R7]
		if (io_clk_en) begin
			nxt_s.prev = s_ff.sync2;
		end
		// Register writes
		if (wr_en) begin
			unique case (paddr)
				ADDR_SENSE: nxt_s.sense = pwdata[7:0];
				ADDR_ENABLE: nxt_s.enable = pwdata[3:0]; // [R11]
				ADDR_FLAGS: nxt_s.flags = s_ff.flags & ~pwdata[3:0]; // [R14]
				ADDR_IRQ_STAT: nxt_s.stat = s_ff.stat & ~pwdata[1:0];
				ADDR_IRQ_MASK: nxt_s.mask = pwdata[1:0];
				ADDR_CTRL: begin
					nxt_s.gie = pwdata[CTRL_GIE_BIT];
					nxt_s.pdown = pwdata[CTRL_PDOWN_BIT];
				end
				default: ;
			endcase
		end
		// Acknowledge from vectoring clears the flag
		nxt_s.flags = nxt_s.flags & ~irq_ack; // [R14] [R16]
		// New edges set after clears so a coincident event is kept
		nxt_s.flags = nxt_s.flags | edge_hit; // [R12]
		// Level lines keep no flag
		nxt_s.flags = nxt_s.flags & ~level_mode; // [R15]
		// Wake ends power-down; sticky events set over a clear
		if (wake_pulse) begin
			nxt_s.pdown = 1'b0;
			nxt_s.stat[STAT_WAKE_BIT] = 1'b1;
		end
		if (wake_noirq) begin
			nxt_s.stat[STAT_WAKE_NOIRQ_BIT] = 1'b1; // [R6]
		end
		// Read data captured in the setup phase, stable through access
		if (rd_en) begin
			unique case (paddr)
				ADDR_SENSE: nxt_s.rdata = {24'h000000, s_ff.sense};
				ADDR_ENABLE: nxt_s.rdata = {28'h0000000, s_ff.enable};
				ADDR_FLAGS: nxt_s.rdata = {28'h0000000, s_ff.flags};
				ADDR_IRQ_STAT: nxt_s.rdata = {30'h0, s_ff.stat};
				ADDR_IRQ_MASK: nxt_s.rdata = {30'h0, s_ff.mask};
				ADDR_CTRL: nxt_s.rdata = {29'h0, wk.wake_busy,
					s_ff.pdown, s_ff.gie};
				default: nxt_s.rdata = 32'h00000000;
			endcase
		end
	end
	// ------------------------------------------------------------
	// State register
	// ------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			s_ff <= '0;
			s_ff.sense <= RST_SENSE;
			s_ff.enable <= RST_ENABLE; // [R11]
			s_ff.flags <= RST_FLAGS;
			s_ff.sync1 <= 4'hF;
			s_ff.sync2 <= 4'hF;
			s_ff.prev <= 4'hF;
		end else begin
			s_ff <= nxt_s;
		end
	end
endmodule : epiu_top
`default_nettype wire

/* File: hw/epiu_pkg.sv */
// Summary of operation
// R1 - An enabled line reacts to its pin even while the pin is driven as an output by this chip.
// R2 - Sense select 00 is low level, 01 any change, 10 falling edge, 11 rising edge.
// R3 - An enabled low-level line keeps its request high while the pin stays low; the code withholds it while a wake waits out its start-up time.
// R4 - Edge and change detection run only on the I/O clock, so they stop when that clock stops.
// R5 - Power-down wake on a level needs two consecutive low samples on the watchdog tick.
// R6 - A wake whose level vanished before start-up ends still wakes but raises no level request.
// R7 - Pin values are sampled first and edges are found from those samples.
// R8 - In edge or change mode a pulse longer than one clock period always gives a request.
// R9 - In low-level mode the outside driver keeps the pin low until the current instruction ends.
// R10 - Software clears a line's enable before changing its sense select.
// R11 - The enable register uses bits 3..0, resets to zero, and bits 7..4 are unused.
// R12 - An edge or change that triggers sets that line's flag.
// R13 - A line vectors only when its flag, its enable and the global enable are all one; the code also vectors an enabled low-level line on its live level.
// R14 - A flag clears when its routine runs (acknowledge) or when software writes one to it.
// R15 - A line in low-level mode holds its flag at zero.
// R16 - Each line drives a request of flag (or live low level) AND enable; acknowledge clears flag.
// R17 - Pins pass a two-stage synchroniser and successive samples are compared for edges.
package epiu_pkg;
	localparam int NUM_LINES = 4;
	localparam logic [7:0] ADDR_SENSE = 8'h00;
	localparam logic [7:0] ADDR_ENABLE = 8'h04;
	localparam logic [7:0] ADDR_FLAGS = 8'h08;
	localparam logic [7:0] ADDR_IRQ_STAT = 8'h0C;
	localparam logic [7:0] ADDR_IRQ_MASK = 8'h10;
	localparam logic [7:0] ADDR_CTRL = 8'h14;
	localparam logic [7:0] RST_SENSE = 8'h00;
	localparam logic [3:0] RST_ENABLE = 4'h0;
	localparam logic [3:0] RST_FLAGS = 4'h0;
	localparam int CTRL_GIE_BIT = 0;
	localparam int CTRL_PDOWN_BIT = 1;
	localparam int STAT_WAKE_BIT = 0;
	localparam int STAT_WAKE_NOIRQ_BIT = 1;
	localparam int STARTUP_TIME_NS = 4000;
	localparam int CLK_PERIOD_NS = 4;
	localparam int STARTUP_CYCLES = (STARTUP_TIME_NS + CLK_PERIOD_NS - 1)
		/ CLK_PERIOD_NS;
	typedef enum logic [1:0] {
		SENSE_LOW,
		SENSE_ANY,
		SENSE_FALL,
		SENSE_RISE
	} epiu_sense_t;
endpackage : epiu_pkg

/* File: hw/epiu_wake_if.sv */
`timescale 1ns/100ps
`default_nettype none
// Signals between the line detector and the power-down wake sequencer
interface epiu_wake_if;
	logic [3:0] level_armed;
	logic [3:0] pin_low;
	logic [3:0] level_gate;
	logic wake_busy;
	modport detector (output level_armed, output pin_low,
		input level_gate, input wake_busy);
	modport sequencer (input level_armed, input pin_low,
		output level_gate, output wake_busy);
endinterface : epiu_wake_if
`default_nettype wire

/* File: hw/epiu_wake.sv */
`timescale 1ns/100ps
`default_nettype none
// Power-down wake sequencer: qualifies a low level on the watchdog tick
module epiu_wake #(
	parameter int STARTUP = epiu_pkg::STARTUP_CYCLES
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic power_down,
	input wire logic wdt_tick,
	epiu_wake_if.sequencer wk,
	output logic wake_req,
	output logic wake_noirq
);
	import epiu_pkg::*;
	typedef enum logic [1:0] {
		W_IDLE,
		W_ONE,
		W_START
	} epiu_wst_t;
	typedef struct packed {
		epiu_wst_t st;
		logic [15:0] cnt;
		logic wake;
		logic noirq;
	} epiu_wstate_t;
	epiu_wstate_t s_ff;
	epiu_wstate_t nxt_s;
	logic any_low;
	// A line counts only while enabled in level mode and pin low
	assign any_low = |(wk.level_armed & wk.pin_low);
	// Outside a wake, level requests pass straight through
	assign wk.level_gate = (s_ff.st == W_START) ? 4'h0 : 4'hF;
	assign wk.wake_busy = (s_ff.st != W_IDLE);
	assign wake_req = s_ff.wake;
	assign wake_noirq = s_ff.noirq;
	// Two tick samples then a start-up wait; the level is checked at the end
	always_comb begin
		nxt_s = s_ff;
		nxt_s.wake = 1'b0;
		nxt_s.noirq = 1'b0;
		unique case (s_ff.st)
			W_IDLE: begin
				if (power_down && wdt_tick && any_low) begin
					nxt_s.st = W_ONE; // [R5]
				end
			end
			W_ONE: begin
				// Leaving power-down between the two ticks abandons the wake
				if (!any_low || !power_down) begin
					nxt_s.st = W_IDLE;
				end else if (wdt_tick) begin
					nxt_s.st = W_START; // [R5]
					nxt_s.cnt = 16'(STARTUP);
				end
			end
			W_START: begin
				if (s_ff.cnt > 16'h0001) begin
					nxt_s.cnt = s_ff.cnt - 16'h0001;
				end else begin
					// Wake regardless; flag a lost level so software knows why
					nxt_s.st = W_IDLE;
					nxt_s.wake = 1'b1; // [R6]
					nxt_s.noirq = !any_low; // [R6]
				end
			end
		endcase
	end
	// State register
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			s_ff <= '{st: W_IDLE, cnt: 16'h0000, wake: 1'b0, noirq: 1'b0};
		end else begin
			s_ff <= nxt_s;
		end
	end
endmodule : epiu_wake
`default_nettype wire

/* File: verification/epiu_checker.sv */
`timescale 1ns/100ps
`default_nettype none
// Port-level checks of the pin interrupt unit
module epiu_checker
	import epiu_pkg::*;
#(
	parameter int STARTUP = 4
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [3:0] ext_irq_pins,
	input wire logic io_clk_en,
	input wire logic [3:0] irq_req,
	input wire logic [3:0] irq_vector,
	input wire logic wake_req,
	input wire logic irq
);
	logic [7:0] sns_ff;
	logic [3:0] en_ff, q1_ff, q2_ff, hit, he, lvl, pl, ph;
	logic gie_ff, pd_ff, wr;
	logic [1:0] msk_ff;
	assign wr = psel && penable && pwrite;
	assign he = hit & en_ff;
	assign pl = ~ext_irq_pins & ~q1_ff & ~q2_ff;
	assign ph = ext_irq_pins & q1_ff & q2_ff;
	// Register shadow; pin samples line up with the two-stage synchroniser
	always_ff @(posedge ref_clk) begin
		q1_ff <= ext_irq_pins;
		q2_ff <= q1_ff;
		if (rst) begin
			{sns_ff, en_ff, gie_ff, pd_ff, msk_ff} <= '0;
		end else begin
			if (wr && paddr == ADDR_SENSE)
				sns_ff <= pwdata[7:0];
			if (wr && paddr == ADDR_ENABLE)
				en_ff <= pwdata[3:0];
			if (wr && paddr == ADDR_IRQ_MASK)
				msk_ff <= pwdata[1:0];
			if (wr && paddr == ADDR_CTRL)
				gie_ff <= pwdata[0];
			// A wake ends power-down even over a write in the same cycle
			if (wake_req)
				pd_ff <= 1'b0;
			else if (wr && paddr == ADDR_CTRL)
				pd_ff <= pwdata[1];
		end
	end
	// Edge hits as each sense select asks, and enabled level lines
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			lvl[i] = en_ff[i] && sns_ff[2*i +: 2] == SENSE_LOW;
			case (sns_ff[2*i +: 2])
				SENSE_ANY: hit[i] = q1_ff[i] ^ q2_ff[i];
				SENSE_FALL: hit[i] = q2_ff[i] & ~q1_ff[i];
				SENSE_RISE: hit[i] = q1_ff[i] & ~q2_ff[i];
				default: hit[i] = 1'b0;
			endcase
		end
	end
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	sequence s_wake;
		wake_req && msk_ff[0];
	endsequence
	AST_READY: assert property (pready)
		else $error("pready low");
	AST_SLVERR: assert property (psel && penable && (paddr > ADDR_CTRL ||
		paddr[1:0] != 2'h0) |-> pslverr)
		else $error("unmapped access without error");
	AST_REQ_EN: assert property ((irq_req & ~en_ff) == 4'h0)
		else $error("request on disabled line");
	AST_VECTOR: assert property (irq_vector == (irq_req & {4{gie_ff}}))
		else $error("vector mismatch");
	AST_LEVEL: assert property (!pd_ff |-> (lvl & pl & ~irq_req) == 4'h0)
		else $error("low level without request");
	AST_LVL_FLAG: assert property ((lvl & ph & irq_req) == 4'h0)
		else $error("flag seen in level mode");
	// The design compares one stage later, so the clock gate is taken there
	AST_EDGE: assert property ($past(he) != 4'h0 &&
		io_clk_en && $past(io_clk_en) |->
		##1 (irq_req & $past(he, 2)) == $past(he, 2))
		else $error("edge lost");
	AST_WAKE: assert property (wake_req |=> !wake_req)
		else $error("wake pulse too long");
	AST_WAKE_PD: assert property (wake_req |-> pd_ff)
		else $error("wake outside power-down");
	AST_IRQ: assert property (s_wake |-> ##[1:3] irq)
		else $error("wake did not interrupt");
	AST_MASKED: assert property (msk_ff == 2'h0 && $past(msk_ff) == 2'h0
		|-> !irq)
		else $error("masked interrupt raised");
endmodule : epiu_checker
bind epiu_top epiu_checker #(.STARTUP(STARTUP)) u_chk (.ref_clk, .rst,
	.psel, .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr,
	.ext_irq_pins, .io_clk_en, .irq_req, .irq_vector, .wake_req, .irq);
`default_nettype wire

/* File: verification/epiu_far_model.sv */
`timescale 1ns/100ps
`default_nettype none
// Pin drivers and the vectoring side
module epiu_far_model (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic [3:0] level,
	input wire logic ack_on,
	input wire logic [3:0] irq_vector,
	output logic [3:0] ext_irq_pins,
	output logic [3:0] irq_ack
);
	// Pins follow the wanted level; a low stays as long as asked
	assign ext_irq_pins = level;
	// One acknowledge per taken vector, never two cycles running
	always_ff @(posedge ref_clk) begin
		if (rst || !ack_on)
			irq_ack <= 4'h0;
		else
			irq_ack <= irq_vector & ~irq_ack;
	end
endmodule : epiu_far_model
`default_nettype wire

/* File: verification/epiu_top_test.sv */
`timescale 1ns/100ps
`default_nettype none
// Register and pin test of the interrupt unit
module epiu_top_test;
	import epiu_pkg::*;
	logic ref_clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0;
	logic pwrite = 1'b0, io_clk_en = 1'b1, wdt_tick = 1'b0, ack_on = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic [3:0] lvl = 4'hF, ext_irq_pins, irq_ack, irq_req, irq_vector;
	logic pready, pslverr, wake_req, irq;
	int miscompares = 0, num_checks = 0;
	// Clock of 4 ns
	always #2 ref_clk = ~ref_clk;
	epiu_top #(.STARTUP(4)) u_dut (.ref_clk, .rst, .psel, .penable, .pwrite,
		.paddr, .pwdata, .prdata, .pready, .pslverr, .ext_irq_pins, .io_clk_en,
		.wdt_tick, .irq_ack, .irq_req, .irq_vector, .wake_req, .irq);
	epiu_far_model u_far (.ref_clk, .rst, .level(lvl), .ack_on, .irq_vector,
		.ext_irq_pins, .irq_ack);
	task automatic wrap_up;
		$display("checks %0d miscompares %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : wrap_up
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask : chk
	task automatic step(input int n);
		repeat (n) @(posedge ref_clk);
	endtask : step
	// One APB transfer; an idle cycle first keeps strobes from doubling up
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge ref_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		do begin
			@(posedge ref_clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		rd = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 20) begin
			miscompares++;
			wrap_up();
		end
	endtask : apb
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask : wr
	task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(rd, exp);
	endtask : rdchk
	// Two-cycle gap then a one-cycle tick; pins take a new level with it
	task automatic tick(input logic [3:0] nl);
		step(2);
		wdt_tick <= 1'b1;
		lvl <= nl;
		step(1);
		wdt_tick <= 1'b0;
	endtask : tick
	task automatic wait_wake;
		int n;
		for (n = 0; n < 40 && wake_req !== 1'b1; n++)
			@(posedge ref_clk);
		if (n >= 40) begin
			miscompares++;
			wrap_up();
		end
	endtask : wait_wake
	// Main sequence
	initial begin
		step(8);
		rst <= 1'b0;
		rdchk(ADDR_SENSE, 32'h0);
		rdchk(ADDR_FLAGS, 32'h0);
		wr(ADDR_ENABLE, 32'hFF);
		rdchk(ADDR_ENABLE, 32'hF);
		wr(ADDR_ENABLE, 32'h0);
		rdchk(8'h18, 32'h0);
		// Lines 0..3: any change, falling, rising, low level
		wr(ADDR_SENSE, 32'h39);
		wr(ADDR_ENABLE, 32'hF);
		lvl <= 4'h0;
		step(6);
		chk(irq_req, 32'hB);
		rdchk(ADDR_FLAGS, 32'h3);
		wr(ADDR_FLAGS, 32'h1);
		rdchk(ADDR_FLAGS, 32'h2);
		lvl <= 4'hF;
		step(6);
		rdchk(ADDR_FLAGS, 32'h7);
		wr(ADDR_FLAGS, 32'hF);
		lvl <= 4'hB;
		step(2);
		lvl <= 4'hF;
		step(6);
		rdchk(ADDR_FLAGS, 32'h4);
		// Vectoring with the global enable, then the acknowledge
		wr(ADDR_CTRL, 32'h1);
		step(2);
		chk(irq_vector, 32'h4);
		ack_on <= 1'b1;
		step(4);
		ack_on <= 1'b0;
		rdchk(ADDR_FLAGS, 32'h0);
		wr(ADDR_CTRL, 32'h0);
		// Pulse while the I/O clock is stopped goes unseen
		io_clk_en <= 1'b0;
		step(1);
		lvl <= 4'hE;
		step(3);
		lvl <= 4'hF;
		step(4);
		io_clk_en <= 1'b1;
		step(4);
		rdchk(ADDR_FLAGS, 32'h0);
		// Power-down: one tick is not enough, two wake the part
		wr(ADDR_IRQ_MASK, 32'h1);
		wr(ADDR_CTRL, 32'h2);
		lvl <= 4'h7;
		step(4);
		tick(4'hF);
		step(10);
		rdchk(ADDR_IRQ_STAT, 32'h0);
		lvl <= 4'h7;
		step(4);
		tick(4'h7);
		tick(4'h7);
		wait_wake();
		rdchk(ADDR_IRQ_STAT, 32'h1);
		rdchk(ADDR_CTRL, 32'h0);
		chk(irq, 32'h1);
		wr(ADDR_IRQ_MASK, 32'h0);
		step(2);
		chk(irq, 32'h0);
		wr(ADDR_IRQ_MASK, 32'h1);
		wr(ADDR_IRQ_STAT, 32'h1);
		step(2);
		chk(irq, 32'h0);
		// Level gone during start-up: wake without a level request
		wr(ADDR_CTRL, 32'h0);
		wr(ADDR_CTRL, 32'h2);
		step(4);
		tick(4'h7);
		tick(4'hF);
		wait_wake();
		rdchk(ADDR_IRQ_STAT, 32'h3);
		// The lost-level status interrupts through its own mask bit
		wr(ADDR_IRQ_STAT, 32'h1);
		wr(ADDR_IRQ_MASK, 32'h2);
		step(1);
		chk(irq, 32'h1);
		wr(ADDR_IRQ_MASK, 32'h0);
		step(1);
		chk(irq, 32'h0);
		wrap_up();
	end
endmodule : epiu_top_test
`default_nettype wire
